// ---- src/bhr_pkg.sv ----
// Constants shared by the bus hold, reset and power signalling block.
package bhr_pkg;
    // ==========================================================
    // Widths
    localparam int ADDR_W = 32;
    localparam int PIN_ADDR_W = 16;
    localparam int DATA_W = 64;
    localparam int CHECK_W = 8;
    localparam int LANE_W = 8;
    localparam int SIZE_W = 3;
    localparam int PWR_W = 2;
    localparam int MULT_W = 3;
    localparam int SEQ_W = 4;

    // ==========================================================
    // Power state codes; code 2'b10 is reserved and never produced.
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_IDLE = 2'h1;
    localparam logic [1:0] PWR_SLEEP = 2'h3;

    // ==========================================================
    // Clock multiplier values chosen by the strap while reset is held.
    localparam logic [2:0] MULT_HIGH = 3'h6;
    localparam logic [2:0] MULT_LOW = 3'h3;

    // ==========================================================
    // Reset figures, in memory clock cycles.
    localparam int RESET_MIN_CYCLES = 32;
    localparam logic [3:0] RESET_SEQ_CYCLES = 4'h8;

    // ==========================================================
    // Field positions of the transfer size code on the shared pins.
    localparam int SIZE_MSB = 2;
    localparam int SIZE_MID = 1;
    localparam int SIZE_LSB = 0;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        BHR_PS_NORMAL,
        BHR_PS_IDLE,
        BHR_PS_SLEEP
    } bhr_pwr_t;

    typedef enum logic [1:0] {
        BHR_BUS_IDLE,
        BHR_BUS_ISSUE1,
        BHR_BUS_ISSUE2,
        BHR_BUS_DATA
    } bhr_bus_t;
endpackage : bhr_pkg

// ---- src/bhr_sync2.sv ----
// Two flip-flop level synchroniser.
`timescale 1ns/1ps
`default_nettype none
module bhr_sync2 #(
    parameter int W = 1
) (
    // Destination clock
    input wire logic clk,
    // Level from the other domain
    input wire logic [W-1:0] d,
    // Synchronised level
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // ==========================================================
    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        meta <= d;
        q <= meta;
    end
endmodule : bhr_sync2
`default_nettype wire

// ---- src/bhr_top.sv ----
// Bus hold, issue-phase encoding, reset, power and interrupt pin logic.
`timescale 1ns/1ps
`default_nettype none
module bhr_top (
    // Core clock domain
    input wire logic core_clk,
    input wire logic srst,
    // Core transaction request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [bhr_pkg::ADDR_W-1:0] req_addr,
    input wire logic req_write,
    input wire logic req_atomic,
    input wire logic [bhr_pkg::SIZE_W-1:0] req_size,
    input wire logic [bhr_pkg::DATA_W-1:0] req_wdata,
    input wire logic [bhr_pkg::CHECK_W-1:0] req_wcheck,
    input wire logic [bhr_pkg::LANE_W-1:0] req_lanes_n,
    output logic req_done,
    output logic [bhr_pkg::DATA_W-1:0] req_rdata,
    output logic [bhr_pkg::CHECK_W-1:0] req_rcheck,
    // Core power, interrupt and configuration
    input wire logic want_idle,
    input wire logic want_sleep,
    input wire logic irq_enable,
    input wire logic irq_request_n,
    output logic irq_take,
    output logic [bhr_pkg::MULT_W-1:0] core_multiplier,
    output logic core_in_reset,
    // Memory clock and bus control pins
    input wire logic mem_clk,
    input wire logic reset_in_n,
    input wire logic multiplier_select,
    input wire logic bus_float_req,
    input wire logic data_valid,
    output logic bus_float_ack,
    output logic reset_status_out_n,
    output logic [bhr_pkg::PWR_W-1:0] power_state_code,
    // Issue-phase pins
    output logic [bhr_pkg::PIN_ADDR_W-1:0] addr_out,
    output logic request_strobe_n,
    output logic atomic_flag,
    output logic write_not_read,
    output logic ctrl_oe,
    // Data-phase lanes
    input wire logic [bhr_pkg::DATA_W-1:0] data_in,
    output logic [bhr_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [bhr_pkg::CHECK_W-1:0] check_byte_bus_in,
    output logic [bhr_pkg::CHECK_W-1:0] check_byte_bus_out,
    output logic check_byte_bus_oe,
    output logic [bhr_pkg::LANE_W-1:0] byte_lane_enables_n,
    output logic byte_lane_enables_oe
);
    import bhr_pkg::*;

    // ==========================================================
    // Core side: request hand-off by toggle, answer by toggle.
    logic req_tgl;
    logic ack_seen;
    logic busy;
    logic [ADDR_W-1:0] c_addr;
    logic c_write;
    logic c_atomic;
    logic [SIZE_W-1:0] c_size;
    logic [DATA_W-1:0] c_wdata;
    logic [CHECK_W-1:0] c_wcheck;
    logic [LANE_W-1:0] c_lanes_n;
    logic ack_tgl;
    logic ack_sync;
    logic [DATA_W-1:0] m_rdata;
    logic [CHECK_W-1:0] m_rcheck;

    bhr_sync2 #(.W(1)) u_ack_sync (
        .clk(core_clk),
        .d(ack_tgl),
        .q(ack_sync)
    );

    wire take_req = req_valid && !busy;
    wire ack_event = busy && (ack_sync != ack_seen);

    // Payload registers stay frozen while busy, so the memory side may
    // read them once it has seen the toggle.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            req_tgl <= 1'b0;
            ack_seen <= 1'b0;
            busy <= 1'b0;
            req_ready <= 1'b0;
            req_done <= 1'b0;
        end else begin
            req_done <= ack_event;
            req_ready <= !busy && !take_req && !ack_event;
            if (take_req) begin
                req_tgl <= !req_tgl;
                busy <= 1'b1;
            end else if (ack_event) begin
                ack_seen <= ack_sync;
                busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            c_addr <= '0;
            c_write <= 1'b0;
            c_atomic <= 1'b0;
            c_size <= '0;
            c_wdata <= '0;
            c_wcheck <= '0;
            c_lanes_n <= '1;
            req_rdata <= '0;
            req_rcheck <= '0;
        end else begin
            if (take_req) begin
                c_addr <= req_addr;
                c_write <= req_write;
                c_atomic <= req_atomic;
                c_size <= req_size;
                c_wdata <= req_wdata;
                c_wcheck <= req_wcheck;
                c_lanes_n <= req_lanes_n;
            end
            if (ack_event) begin
                req_rdata <= m_rdata;
                req_rcheck <= m_rcheck;
            end
        end
    end

    // ==========================================================
    // Core side: power state walks one step at a time, so the code
    // changes one bit per step and the crossing never shows 2'b10.
    bhr_pwr_t pwr;
    bhr_pwr_t next_pwr;
    logic [PWR_W-1:0] pwr_code;

    always_comb begin
        next_pwr = pwr;
        case (pwr)
            BHR_PS_NORMAL: begin
                if (want_idle || want_sleep) begin
                    next_pwr = BHR_PS_IDLE;
                end
            end
            BHR_PS_IDLE: begin
                if (want_sleep) begin
                    next_pwr = BHR_PS_SLEEP;
                end else if (!want_idle) begin
                    next_pwr = BHR_PS_NORMAL;
                end
            end
            BHR_PS_SLEEP: begin
                if (!want_sleep) begin
                    next_pwr = BHR_PS_IDLE;
                end
            end
            default: begin
                next_pwr = BHR_PS_NORMAL;
            end
        endcase
    end

    wire [PWR_W-1:0] next_pwr_code = (next_pwr == BHR_PS_SLEEP) ? PWR_SLEEP :
                                     (next_pwr == BHR_PS_IDLE) ? PWR_IDLE : PWR_NORMAL;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pwr <= BHR_PS_NORMAL;
            pwr_code <= PWR_NORMAL;
        end else begin
            pwr <= next_pwr;
            pwr_code <= next_pwr_code;
        end
    end

    // ==========================================================
    // Core side: interrupt pin and reset-time configuration.
    logic irq_sync;
    logic mult_high_sync;
    logic in_reset_sync;
    logic mult_high;
    logic m_in_reset;

    bhr_sync2 #(.W(3)) u_core_sync (
        .clk(core_clk),
        .d({irq_request_n, mult_high, m_in_reset}),
        .q({irq_sync, mult_high_sync, in_reset_sync})
    );

    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_take <= 1'b0;
            core_multiplier <= MULT_LOW;
            core_in_reset <= 1'b1;
        end else begin
            irq_take <= irq_enable && !irq_sync;
            // Follow the strap only while the reset sequence runs, so the value
            // is frozen afterwards and never shows an unsampled strap.
            if (in_reset_sync) begin
                core_multiplier <= mult_high_sync ? MULT_HIGH : MULT_LOW;
            end
            core_in_reset <= in_reset_sync;
        end
    end

    // ==========================================================
    // Memory side: every flop below runs on the memory clock.
    logic rstn_sync;
    logic strap_sync;
    logic srst_m;
    logic req_sync;
    logic [PWR_W-1:0] pwr_sync;

    bhr_sync2 #(.W(4)) u_mem_sync (
        .clk(mem_clk),
        .d({reset_in_n, multiplier_select, srst, req_tgl}),
        .q({rstn_sync, strap_sync, srst_m, req_sync})
    );

    bhr_sync2 #(.W(PWR_W)) u_pwr_sync (
        .clk(mem_clk),
        .d(pwr_code),
        .q(pwr_sync)
    );

    // ==========================================================
    // Reset sequence. The agent keeps the reset pin low for its minimum
    // time; the device only counts its own sequence after the release.
    logic [SEQ_W-1:0] seq_cnt;
    wire seq_done = (seq_cnt == RESET_SEQ_CYCLES);

    always_ff @(posedge mem_clk) begin
        if (!rstn_sync || srst_m) begin
            seq_cnt <= '0;
            reset_status_out_n <= 1'b0;
            m_in_reset <= 1'b1;
        end else begin
            if (!seq_done) begin
                seq_cnt <= seq_cnt + 4'h1;
            end
            reset_status_out_n <= seq_done;
            m_in_reset <= !seq_done;
        end
    end

    // The strap is caught by a clocked sample while reset is held.
    always_ff @(posedge mem_clk) begin
        if (!rstn_sync) begin
            mult_high <= strap_sync;
        end
    end

    always_ff @(posedge mem_clk) begin
        if (m_in_reset) begin
            power_state_code <= PWR_NORMAL;
        end else begin
            power_state_code <= pwr_sync;
        end
    end

    // ==========================================================
    // Bus sequencer.
    bhr_bus_t bus;
    bhr_bus_t next_bus;
    logic req_seen;
    logic m_write;

    wire new_req = (req_sync != req_seen) && !m_in_reset;

    always_comb begin
        next_bus = bus;
        case (bus)
            BHR_BUS_IDLE: begin
                // A float request blocks any new issue phase.
                if (new_req && !bus_float_req) begin
                    next_bus = BHR_BUS_ISSUE1;
                end
            end
            BHR_BUS_ISSUE1: begin
                next_bus = BHR_BUS_ISSUE2;
            end
            BHR_BUS_ISSUE2: begin
                next_bus = BHR_BUS_DATA;
            end
            BHR_BUS_DATA: begin
                if (data_valid) begin
                    next_bus = BHR_BUS_IDLE;
                end
            end
            default: begin
                next_bus = BHR_BUS_IDLE;
            end
        endcase
    end

    // Control pins float at once under hold except mid issue; data lanes
    // keep their value until the pending transfer is over.
    wire next_issuing = (next_bus == BHR_BUS_ISSUE1) || (next_bus == BHR_BUS_ISSUE2);
    wire next_ctrl_float = bus_float_req && !next_issuing;
    wire next_lanes_drive = (next_bus == BHR_BUS_DATA) && m_write;
    wire next_ack = bus_float_req && (next_bus == BHR_BUS_IDLE);
    wire finish = (bus == BHR_BUS_DATA) && data_valid;

    always_ff @(posedge mem_clk) begin
        if (m_in_reset) begin
            bus <= BHR_BUS_IDLE;
            req_seen <= req_sync;
            ack_tgl <= 1'b0;
            m_write <= 1'b0;
        end else begin
            bus <= next_bus;
            if (next_bus == BHR_BUS_ISSUE1) begin
                req_seen <= req_sync;
                m_write <= c_write;
            end
            if (finish) begin
                ack_tgl <= !ack_tgl;
            end
        end
    end

    always_ff @(posedge mem_clk) begin
        if (m_in_reset) begin
            m_rdata <= '0;
            m_rcheck <= '0;
        end else if (finish && !m_write) begin
            m_rdata <= data_in;
            m_rcheck <= check_byte_bus_in;
        end
    end

    // ==========================================================
    // Pin drivers. In reset the strobe idles high unless hold wins.
    always_ff @(posedge mem_clk) begin
        if (m_in_reset) begin
            bus_float_ack <= next_ack;
            ctrl_oe <= !next_ctrl_float;
            request_strobe_n <= 1'b1;
            atomic_flag <= 1'b0;
            write_not_read <= 1'b0;
            addr_out <= '0;
        end else begin
            bus_float_ack <= next_ack;
            ctrl_oe <= !next_ctrl_float;
            case (next_bus)
                BHR_BUS_ISSUE1: begin
                    request_strobe_n <= 1'b0;
                    atomic_flag <= c_atomic;
                    write_not_read <= c_write;
                    addr_out <= c_addr[ADDR_W-1:PIN_ADDR_W];
                end
                BHR_BUS_ISSUE2: begin
                    request_strobe_n <= c_size[SIZE_MSB];
                    atomic_flag <= c_size[SIZE_MID];
                    write_not_read <= c_size[SIZE_LSB];
                    addr_out <= c_addr[PIN_ADDR_W-1:0];
                end
                default: begin
                    request_strobe_n <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mem_clk) begin
        if (m_in_reset) begin
            data_oe <= 1'b0;
            check_byte_bus_oe <= 1'b0;
            byte_lane_enables_oe <= 1'b0;
            data_out <= '0;
            check_byte_bus_out <= '0;
            byte_lane_enables_n <= '1;
        end else begin
            data_oe <= next_lanes_drive;
            check_byte_bus_oe <= next_lanes_drive;
            byte_lane_enables_oe <= next_lanes_drive;
            if (next_bus == BHR_BUS_ISSUE2) begin
                data_out <= c_wdata;
                check_byte_bus_out <= c_wcheck;
                byte_lane_enables_n <= c_lanes_n;
            end
        end
    end
endmodule : bhr_top
`default_nettype wire

// ---- verif/bhr_agent.sv ----
// External bus agent model on the memory clock.
`timescale 1ns/1ps
`default_nettype none
module bhr_agent (
    // Memory clock
    input wire logic mem_clk,
    // Pins towards the block
    output logic reset_in_n,
    output logic multiplier_select,
    output logic bus_float_req,
    output logic data_valid,
    output logic [bhr_pkg::DATA_W-1:0] data_in,
    output logic [bhr_pkg::CHECK_W-1:0] check_byte_bus_in,
    // Issue pins watched
    input wire logic [bhr_pkg::PIN_ADDR_W-1:0] addr_out,
    input wire logic request_strobe_n,
    input wire logic ctrl_oe
);
    import bhr_pkg::*;
    logic strap = 1'b1;
    logic float_on = 1'b0;
    int dv_delay = 0;
    int wait_cnt = 0;
    logic busy = 1'b0;
    logic in2 = 1'b0;
    logic [31:0] addr = '0;
    logic first;
    assign first = ctrl_oe === 1'b1 && request_strobe_n === 1'b0 && !in2;
    initial begin
        {reset_in_n, multiplier_select, bus_float_req, data_valid} = 4'h4;
        {data_in, check_byte_bus_in} = '0;
    end
    // Held two cycles past the minimum so edge alignment never cuts it short.
    task automatic do_reset();
        @(posedge mem_clk);
        reset_in_n <= 1'b0;
        repeat (RESET_MIN_CYCLES + 2) @(posedge mem_clk);
        reset_in_n <= 1'b1;
    endtask : do_reset
    // Released lanes toggle every cycle so a stale value is never mistaken for data.
    always @(posedge mem_clk) begin
        bus_float_req <= float_on;
        multiplier_select <= strap;
        data_valid <= 1'b0;
        data_in <= ~data_in;
        check_byte_bus_in <= ~check_byte_bus_in;
        in2 <= first;
        if (first) begin
            addr[31:16] <= addr_out;
        end
        if (in2) begin
            addr[15:0] <= addr_out;
            wait_cnt <= dv_delay;
            busy <= 1'b1;
        end else if (busy && wait_cnt != 0) begin
            wait_cnt <= wait_cnt - 1;
        end else if (busy) begin
            data_valid <= 1'b1;
            data_in <= {~addr, addr};
            check_byte_bus_in <= addr[7:0] ^ 8'h5A;
            busy <= 1'b0;
        end
    end
endmodule : bhr_agent
`default_nettype wire

// ---- verif/bhr_chk.sv ----
// Concurrent checks on the pins of the bus hold, reset and power block.
`timescale 1ns/1ps
`default_nettype none
module bhr_chk (
    // Clocks and resets
    input wire logic core_clk,
    input wire logic srst,
    input wire logic mem_clk,
    input wire logic reset_in_n,
    // Core side
    input wire logic irq_enable,
    input wire logic irq_request_n,
    input wire logic irq_take,
    input wire logic [bhr_pkg::MULT_W-1:0] core_multiplier,
    // Bus side
    input wire logic bus_float_req,
    input wire logic data_valid,
    input wire logic bus_float_ack,
    input wire logic reset_status_out_n,
    input wire logic [bhr_pkg::PWR_W-1:0] power_state_code,
    input wire logic request_strobe_n,
    input wire logic write_not_read,
    input wire logic ctrl_oe,
    input wire logic data_oe,
    input wire logic check_byte_bus_oe,
    input wire logic byte_lane_enables_oe
);
    import bhr_pkg::*;
    // ==========================================================
    // Issue tracker: the second issue cycle may also show a low strobe.
    logic second;
    logic first;
    assign first = ctrl_oe && !request_strobe_n && !second;
    always_ff @(posedge mem_clk) begin
        if (!reset_in_n) begin
            second <= 1'b0;
        end else begin
            second <= first;
        end
    end
    // ==========================================================
    // Bus hold
    property p_ack_floated;
        @(posedge mem_clk) disable iff (srst)
        bus_float_ack |-> !ctrl_oe && !data_oe && !check_byte_bus_oe && !byte_lane_enables_oe;
    endproperty
    a_ack_floated: assert property (p_ack_floated) else $error("ack with pins driven");
    property p_release;
        @(posedge mem_clk) disable iff (srst) !bus_float_req |=> !bus_float_ack;
    endproperty
    a_release: assert property (p_release) else $error("ack without request");
    property p_float_rst;
        @(posedge mem_clk) disable iff (srst)
        !reset_status_out_n && bus_float_req |=> bus_float_ack;
    endproperty
    a_float_rst: assert property (p_float_rst) else $error("float ignored in reset");
    property p_data_hold;
        @(posedge mem_clk) disable iff (srst || !reset_in_n)
        data_oe && !data_valid |=> data_oe;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("lanes dropped early");
    property p_dir_oe;
        @(posedge mem_clk) disable iff (srst || !reset_in_n)
        first |=> ##1 data_oe == $past(write_not_read, 2);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("direction and lanes disagree");
    // ==========================================================
    // Reset and power
    property p_pwr;
        @(posedge mem_clk) disable iff (srst || !reset_in_n) power_state_code != 2'h2;
    endproperty
    a_pwr: assert property (p_pwr) else $error("reserved power code");
    property p_rst_on;
        @(posedge mem_clk) disable iff (srst) $fell(reset_in_n) |-> ##[1:4] !reset_status_out_n;
    endproperty
    a_rst_on: assert property (p_rst_on) else $error("reset status late");
    property p_rst_off;
        @(posedge mem_clk) disable iff (srst)
        $rose(reset_in_n) |-> (!reset_status_out_n) [*8] ##[1:8] reset_status_out_n;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("reset status release wrong");
    // ==========================================================
    // Core side
    property p_irq_on;
        @(posedge core_clk) disable iff (srst) (irq_enable && !irq_request_n) [*4] |=> irq_take;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt not taken");
    property p_irq_off;
        @(posedge core_clk) disable iff (srst) (!irq_enable || irq_request_n) [*4] |=> !irq_take;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt taken wrongly");
    property p_mult;
        @(posedge core_clk) disable iff (srst)
        core_multiplier == MULT_HIGH || core_multiplier == MULT_LOW;
    endproperty
    a_mult: assert property (p_mult) else $error("bad multiplier");
endmodule : bhr_chk

bind bhr_top bhr_chk chk_u (.*);
`default_nettype wire

// ---- verif/bhr_top_tb.sv ----
// Self-checking testbench for the bus hold, reset and power block.
`timescale 1ns/1ps
`default_nettype none
module bhr_top_tb;
    import bhr_pkg::*;
    typedef struct packed {
        logic w; logic a; logic [2:0] sz; logic [31:0] ad;
        logic [63:0] wd; logic [7:0] wc; logic [7:0] ln;
    } bhr_note_t;
    logic core_clk = 1'b0, mem_clk = 1'b0, srst = 1'b1;
    logic req_valid = 1'b0, req_write = 1'b0, req_atomic = 1'b0;
    logic [31:0] req_addr = '0;
    logic [2:0] req_size = '0;
    logic [63:0] req_wdata = '0;
    logic [7:0] req_wcheck = '0, req_lanes_n = '0;
    logic want_idle = 1'b0, want_sleep = 1'b0, irq_enable = 1'b0, irq_request_n = 1'b1;
    logic req_ready, req_done, irq_take, core_in_reset, reset_in_n, multiplier_select;
    logic bus_float_req, data_valid, bus_float_ack, reset_status_out_n, request_strobe_n;
    logic atomic_flag, write_not_read, ctrl_oe, data_oe, check_byte_bus_oe, byte_lane_enables_oe;
    logic [63:0] req_rdata, data_in, data_out;
    logic [7:0] req_rcheck, check_byte_bus_in, check_byte_bus_out, byte_lane_enables_n;
    logic [2:0] core_multiplier;
    logic [1:0] power_state_code;
    logic [15:0] addr_out;
    int errors = 0, checks = 0, n_issue = 0;
    bhr_note_t iq[$], dq[$], cur, dn;
    logic second = 1'b0;
    logic issue_first;
    assign issue_first = ctrl_oe === 1'b1 && request_strobe_n === 1'b0 && !second;
    always #12.5 core_clk = ~core_clk;
    initial begin
        #7;
        forever #80 mem_clk = ~mem_clk;
    end
    bhr_top dut_u (.*);
    bhr_agent agent_u (.mem_clk, .reset_in_n, .multiplier_select, .bus_float_req, .data_valid,
        .data_in, .check_byte_bus_in, .addr_out, .request_strobe_n, .ctrl_oe);
    // ==========================================================
    // Compare and closing tasks
    task automatic cmp_core(input logic [71:0] got, input logic [71:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t core %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_core
    task automatic cmp_bus(input logic [71:0] got, input logic [71:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t bus %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_bus
    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // ==========================================================
    // Monitors take the oldest note as each result appears
    always @(posedge mem_clk) begin
        if (issue_first) begin
            cur = iq.pop_front();
            n_issue++;
            cmp_bus({write_not_read, atomic_flag, addr_out}, {cur.w, cur.a, cur.ad[31:16]}, "issue");
        end else if (second) begin
            cmp_bus({request_strobe_n, atomic_flag, write_not_read}, cur.sz, "size");
        end
        if (data_valid === 1'b1 && cur.w === 1'b1) begin
            cmp_bus({check_byte_bus_out, data_out}, {cur.wc, cur.wd}, "wdata");
            cmp_bus(byte_lane_enables_n, cur.ln, "lanes");
        end
        second <= issue_first;
    end
    always @(posedge core_clk) begin
        if (req_done === 1'b1) begin
            dn = dq.pop_front();
            if (!dn.w) cmp_core({req_rcheck, req_rdata}, {dn.ad[7:0] ^ 8'h5A, ~dn.ad, dn.ad}, "rdata");
        end
    end
    // ==========================================================
    // Drivers
    task automatic do_req(input logic w, input logic [2:0] sz);
        bhr_note_t n;
        int i;
        n.w = w;
        n.sz = sz;
        n.ad = $urandom;
        n.wd = {$urandom, $urandom};
        {n.a, n.wc, n.ln} = 17'($urandom);
        for (i = 0; i < 4000 && req_ready !== 1'b1; i++) @(negedge core_clk);
        iq.push_back(n);
        dq.push_back(n);
        {req_write, req_atomic, req_size, req_addr, req_wdata, req_wcheck, req_lanes_n} = n;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
    endtask : do_req
    task automatic wait_idle();
        int i;
        for (i = 0; i < 4000 && (dq.size() != 0 || req_ready !== 1'b1); i++) @(negedge core_clk);
    endtask : wait_idle
    task automatic wait_pwr(input logic [1:0] code);
        int i;
        for (i = 0; i < 400 && power_state_code !== code; i++) @(negedge core_clk);
        cmp_bus(power_state_code, code, "power");
    endtask : wait_pwr
    task automatic wait_ack(input logic v);
        int i;
        for (i = 0; i < 400 && bus_float_ack !== v; i++) @(negedge core_clk);
        cmp_bus(bus_float_ack, v, "float ack");
    endtask : wait_ack
    task automatic wait_rst();
        int i;
        for (i = 0; i < 800 && core_in_reset !== 1'b0; i++) @(negedge core_clk);
        cmp_bus(reset_status_out_n, 1'b1, "reset status");
    endtask : wait_rst
    // ==========================================================
    // Main sequence
    initial begin
        int i, k;
        void'($urandom(29));
        repeat (10) @(negedge core_clk);
        srst = 1'b0;
        agent_u.do_reset();
        wait_rst();
        cmp_core(core_multiplier, MULT_HIGH, "mult high");
        $display("test reset done");
        for (i = 0; i < 16; i++) begin
            agent_u.dv_delay = $urandom_range(0, 4);
            do_req(i[0], i[3:1]);
        end
        wait_idle();
        $display("test transfers done");
        agent_u.dv_delay = 12;
        do_req(1'b1, 3'h2);
        for (i = 0; i < 400 && data_oe !== 1'b1; i++) @(negedge core_clk);
        agent_u.float_on = 1'b1;
        repeat (3) @(posedge mem_clk);
        @(negedge core_clk);
        cmp_bus({bus_float_ack, data_oe}, 2'h1, "hold lanes");
        wait_ack(1'b1);
        k = n_issue;
        do_req(1'b0, 3'h7);
        repeat (10) @(posedge mem_clk);
        cmp_bus(n_issue, k, "issue in hold");
        agent_u.float_on = 1'b0;
        wait_ack(1'b0);
        wait_idle();
        $display("test hold done");
        want_idle = 1'b1;
        wait_pwr(PWR_IDLE);
        want_sleep = 1'b1;
        wait_pwr(PWR_SLEEP);
        agent_u.float_on = 1'b1;
        wait_ack(1'b1);
        agent_u.float_on = 1'b0;
        wait_ack(1'b0);
        {want_idle, want_sleep} = 2'h0;
        wait_pwr(PWR_NORMAL);
        $display("test power done");
        for (i = 0; i < 3; i++) begin
            {irq_enable, irq_request_n} = 2'(i + 1);
            repeat (6) @(negedge core_clk);
            cmp_core(irq_take, i == 1, "irq");
        end
        $display("test irq done");
        agent_u.strap = 1'b0;
        agent_u.float_on = 1'b1;
        agent_u.do_reset();
        @(negedge core_clk);
        cmp_bus({reset_status_out_n, bus_float_ack}, 2'h1, "hold in reset");
        agent_u.float_on = 1'b0;
        wait_rst();
        cmp_core(core_multiplier, MULT_LOW, "mult low");
        cmp_core(dq.size(), 0, "pending");
        $display("test second reset done");
        test_done();
    end
    initial begin
        #1000000;
        errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        test_done();
    end
endmodule : bhr_top_tb
`default_nettype wire
